// ==== acl_pkg.sv ====
/*
 constants for the serial audio link host: frame geometry, clock rates, reset-time
 windows. assumes a 40 MHz system clock and a link reference clock supplied from outside.
*/
package acl_pkg;
   localparam int SYS_CLK_HZ = 40_000_000;
   localparam int FRAME_HZ = 48_000;
   localparam int LEGACY_BCLK_HZ = 12_288_000;
   localparam int HD_BCLK_HZ = 24_000_000;
   // slots are link clock cycles; in high definition mode each cycle is a half bit clock
   localparam int LEGACY_SLOTS = LEGACY_BCLK_HZ / FRAME_HZ;
   localparam int HD_SLOTS = 2 * HD_BCLK_HZ / FRAME_HZ;
   localparam int POS_W = 10;
   localparam logic [POS_W-1:0] LEGACY_LAST = POS_W'(LEGACY_SLOTS - 1);
   localparam logic [POS_W-1:0] HD_LAST = POS_W'(HD_SLOTS - 1);
   localparam logic [POS_W-1:0] SYNC_SLOTS_LEGACY = 10'h010;
   localparam logic [POS_W-1:0] SYNC_SLOTS_HD = 10'h008;
   localparam int STREAM_W = 4;
   localparam int STRAP_HOLD_NS = 1000;
   localparam int STRAP_HOLD_CYC = (STRAP_HOLD_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CRST_DELAY_NS = 2000;
   localparam int CRST_DELAY_CYC = (CRST_DELAY_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int CNT_W = 8;
   typedef enum logic [1:0] {ACL_ST_STRAP, ACL_ST_WAKE, ACL_ST_RUN} acl_state_t;
endpackage

// ==== acl_sync.sv ====
/*
 two flip-flop synchroniser for levels and toggles.
 assumes each bit is independent; multi-bit words must be held stable by their source.
*/
`timescale 1ns/1ps
`default_nettype none
module acl_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ==== acl_link.sv ====
/*
 host end of a time-division multiplexed serial audio link to up to three codecs.
 assumes LINK_CLK is the codec bit clock in legacy mode and a 48 MHz reference in
 high definition mode; HD_MODE is static while the link runs.
*/
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RQ1: names ending _N are active low
// RQ2: drive active-low master reset to codecs
// RQ3: frame sync repeats at 48 kHz
// RQ4: frame sync also carries stream number
// RQ5: legacy mode takes bit clock from codec
// RQ6: high definition mode drives 24 MHz clock
// RQ7: serial out double pumped in high definition
// RQ8: three inputs, sampled once per bit clock
// RQ9: sync and data out strapped during reset
// RQ10: static mode picks clock direction, pumping
// RQ11: sync and data change on clock edges
module acl_link import acl_pkg::*; #(
   parameter int DATA_W = 20
) (
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic LINK_CLK,
   input wire logic HD_MODE,
   input wire logic CODEC_RESET_HOLD,
   input wire logic [STREAM_W-1:0] STREAM_NUM,
   input wire logic TX_LOAD,
   input wire logic [DATA_W-1:0] TX_DATA,
   output logic TX_READY,
   output logic [DATA_W-1:0] RX_DATA0,
   output logic [DATA_W-1:0] RX_DATA1,
   output logic [DATA_W-1:0] RX_DATA2,
   output logic RX_VALID,
   output logic CODEC_RESET_N,
   output logic STRAP_SYNC,
   output logic STRAP_SDO,
   output logic FRAME_SYNC_O,
   output logic FRAME_SYNC_OE_N,
   input wire logic FRAME_SYNC_I,
   output logic SERIAL_OUT_LINE_O,
   output logic SERIAL_OUT_LINE_OE_N,
   input wire logic SERIAL_OUT_LINE_I,
   output logic LINK_BIT_CLOCK_O,
   output logic LINK_BIT_CLOCK_OE_N,
   input wire logic [2:0] SERIAL_IN_LINES
);
   localparam int WORD_W = STREAM_W + DATA_W;

   if (DATA_W < 2 || 32 + STREAM_W + 2 * DATA_W > LEGACY_SLOTS) begin : g_chk
      $error("DATA_W does not fit in a frame");
   end

   // system clock domain
   acl_state_t state_q;
   logic [CNT_W-1:0] cnt_q;
   logic drive_en_q;
   logic [1:0] strap_s;
   logic tx_tgl_q, tx_ack_s, tx_busy_q;
   logic [WORD_W-1:0] tx_hold_q;
   logic rx_tgl_s, rx_seen_q;
   // link clock domain
   logic lrst_meta_q, lrst_n_q;
   logic [2:0] ctl_s;
   logic [2:0] sdi_s;
   logic hd_l, drive_l, tx_tgl_l;
   logic [POS_W-1:0] pos_q, last_pos, sync_len, idx;
   logic bclk_q, tx_ack_q, rx_tgl_q;
   logic [DATA_W-1:0] tx_word_q;
   logic [STREAM_W-1:0] stream_q;
   logic [DATA_W-1:0] rx_shift_q [3];
   logic [DATA_W-1:0] rx_hold_q [3];
   logic [POS_W-1:0] rx_cnt_q;
   logic sample_en, rx_win;

   acl_sync #(.W(2)) u_strap_sync (.clk(CLK), .rst_n(RESETN),
      .d({FRAME_SYNC_I, SERIAL_OUT_LINE_I}), .q(strap_s));
   acl_sync #(.W(2)) u_back_sync (.clk(CLK), .rst_n(RESETN),
      .d({tx_ack_q, rx_tgl_q}), .q({tx_ack_s, rx_tgl_s}));

   // pins stay released until the straps are caught, then codec reset follows
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_q <= ACL_ST_STRAP;
         cnt_q <= '0;
         drive_en_q <= 1'b0;
         STRAP_SYNC <= 1'b0;
         STRAP_SDO <= 1'b0;
      end else begin
         case (state_q)
            ACL_ST_STRAP: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == CNT_W'(STRAP_HOLD_CYC - 1)) begin
                  {STRAP_SYNC, STRAP_SDO} <= strap_s; // RQ9
                  drive_en_q <= 1'b1;
                  cnt_q <= '0;
                  state_q <= ACL_ST_WAKE;
               end
            end
            ACL_ST_WAKE: begin
               cnt_q <= cnt_q + 1'b1;
               if (cnt_q == CNT_W'(CRST_DELAY_CYC - 1)) begin
                  state_q <= ACL_ST_RUN;
               end
            end
            default: begin
               state_q <= ACL_ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         CODEC_RESET_N <= 1'b0;
      end else begin
         CODEC_RESET_N <= (state_q == ACL_ST_RUN) && !CODEC_RESET_HOLD; // RQ1 RQ2
      end
   end

   // word to send: held stable until the link side acknowledges by toggle
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         tx_tgl_q <= 1'b0;
         tx_busy_q <= 1'b0;
         TX_READY <= 1'b0;
         tx_hold_q <= '0;
      end else begin
         if (TX_LOAD && TX_READY) begin
            tx_hold_q <= {STREAM_NUM, TX_DATA};
            tx_tgl_q <= !tx_tgl_q;
            tx_busy_q <= 1'b1;
            TX_READY <= 1'b0;
         end else begin
            tx_busy_q <= tx_busy_q && (tx_ack_s != tx_tgl_q);
            TX_READY <= drive_en_q && !(tx_busy_q && (tx_ack_s != tx_tgl_q));
         end
      end
   end

   // received words: link holds them a whole frame, far longer than the crossing
   always_ff @(posedge CLK or negedge RESETN) begin
      if (!RESETN) begin
         rx_seen_q <= 1'b0;
         RX_VALID <= 1'b0;
         RX_DATA0 <= '0;
         RX_DATA1 <= '0;
         RX_DATA2 <= '0;
      end else begin
         RX_VALID <= rx_tgl_s != rx_seen_q;
         rx_seen_q <= rx_tgl_s;
         if (rx_tgl_s != rx_seen_q) begin
            RX_DATA0 <= rx_hold_q[0];
            RX_DATA1 <= rx_hold_q[1];
            RX_DATA2 <= rx_hold_q[2];
         end
      end
   end

   // link domain reset: asserted at once, released on LINK_CLK
   always_ff @(posedge LINK_CLK or negedge RESETN) begin
      if (!RESETN) begin
         lrst_meta_q <= 1'b0;
         lrst_n_q <= 1'b0;
      end else begin
         lrst_meta_q <= 1'b1;
         lrst_n_q <= lrst_meta_q;
      end
   end

   acl_sync #(.W(3)) u_ctl_sync (.clk(LINK_CLK), .rst_n(lrst_n_q),
      .d({HD_MODE, drive_en_q, tx_tgl_q}), .q(ctl_s));
   acl_sync #(.W(3)) u_sdi_sync (.clk(LINK_CLK), .rst_n(lrst_n_q),
      .d(SERIAL_IN_LINES), .q(sdi_s));

   assign {hd_l, drive_l, tx_tgl_l} = ctl_s;
   assign last_pos = hd_l ? HD_LAST : LEGACY_LAST; // RQ10
   assign sync_len = hd_l ? SYNC_SLOTS_HD : SYNC_SLOTS_LEGACY;
   assign idx = pos_q - sync_len;
   // inputs are single pumped: one sample per bit clock in high definition mode
   assign sample_en = !hd_l || bclk_q; // RQ8
   // idx wraps around inside the sync head, so the window is judged on pos_q itself
   assign rx_win = pos_q >= sync_len + POS_W'(STREAM_W) && rx_cnt_q < POS_W'(DATA_W)
      && sample_en;

   always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         pos_q <= '0;
         bclk_q <= 1'b0;
         LINK_BIT_CLOCK_O <= 1'b0;
         LINK_BIT_CLOCK_OE_N <= 1'b1;
      end else begin
         pos_q <= (!drive_l || pos_q == last_pos) ? '0 : pos_q + 1'b1; // RQ3
         bclk_q <= hd_l && drive_l && !bclk_q; // RQ6
         LINK_BIT_CLOCK_O <= hd_l && drive_l && !bclk_q;
         LINK_BIT_CLOCK_OE_N <= !(hd_l && drive_l); // RQ5 RQ10
      end
   end

   // a fresh word is taken only at the frame boundary; otherwise the slot sends zeros
   always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         tx_ack_q <= 1'b0;
         tx_word_q <= '0;
         stream_q <= '0;
      end else if (drive_l && pos_q == last_pos) begin
         if (tx_tgl_l != tx_ack_q) begin
            tx_ack_q <= tx_tgl_l;
            {stream_q, tx_word_q} <= tx_hold_q;
         end else begin
            tx_word_q <= '0;
         end
      end
   end

   // outputs are registered on LINK_CLK, so they move only with bit clock edges
   always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         FRAME_SYNC_O <= 1'b0;
         FRAME_SYNC_OE_N <= 1'b1;
         SERIAL_OUT_LINE_O <= 1'b0;
         SERIAL_OUT_LINE_OE_N <= 1'b1;
      end else begin
         FRAME_SYNC_OE_N <= !drive_l; // RQ9
         SERIAL_OUT_LINE_OE_N <= !drive_l;
         FRAME_SYNC_O <= 1'b0;
         SERIAL_OUT_LINE_O <= 1'b0;
         if (drive_l) begin
            if (pos_q < sync_len) begin
               FRAME_SYNC_O <= 1'b1; // RQ3 RQ11
            end else if (idx < POS_W'(STREAM_W)) begin
               FRAME_SYNC_O <= stream_q[STREAM_W - 1 - int'(idx)]; // RQ4
            end else if (idx < POS_W'(STREAM_W + DATA_W)) begin
               // one bit per link clock: double pumped in high definition mode
               SERIAL_OUT_LINE_O <= tx_word_q[DATA_W - 1 - (int'(idx) - STREAM_W)]; // RQ7
            end
         end
      end
   end

   always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
      if (!lrst_n_q) begin
         rx_cnt_q <= '0;
         rx_tgl_q <= 1'b0;
      end else if (pos_q == last_pos) begin
         rx_cnt_q <= '0;
         rx_tgl_q <= drive_l ? !rx_tgl_q : rx_tgl_q;
      end else if (rx_win) begin
         rx_cnt_q <= rx_cnt_q + 1'b1; // RQ8
      end
   end

   for (genvar i = 0; i < 3; i++) begin : g_rx
      always_ff @(posedge LINK_CLK or negedge lrst_n_q) begin
         if (!lrst_n_q) begin
            rx_shift_q[i] <= '0;
            rx_hold_q[i] <= '0;
         end else if (pos_q == last_pos) begin
            rx_hold_q[i] <= rx_shift_q[i];
         end else if (rx_win) begin
            rx_shift_q[i] <= {rx_shift_q[i][DATA_W-2:0], sdi_s[i]}; // RQ8
         end
      end
   end

   sequence s_frame_wrap;
      drive_l && pos_q == last_pos;
   endsequence
   sequence s_sync_head;
      FRAME_SYNC_O [*8];
   endsequence

   a_codec_reset_held: assert property (@(posedge CLK) disable iff (!RESETN)
      !drive_en_q |-> !CODEC_RESET_N) else $error("codec reset released early"); // RQ2 RQ1
   a_frame_wrap_pos: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
      s_frame_wrap |=> pos_q == '0 ##1 pos_q == 10'h001) else $error("frame length wrong"); // RQ3
   a_sync_head_width: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
      s_frame_wrap ##1 drive_l |=> s_sync_head) else $error("frame sync head short"); // RQ3 RQ11
   a_stream_msb_slot: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
      drive_l && idx == '0 |=> FRAME_SYNC_O == stream_q[STREAM_W-1])
      else $error("stream number not on sync"); // RQ4
   a_legacy_clock_in: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
      !hd_l ##1 !hd_l |-> LINK_BIT_CLOCK_OE_N) else $error("bit clock driven in legacy"); // RQ5
   a_hd_clock_toggle: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
      (hd_l && drive_l) [*3] |-> LINK_BIT_CLOCK_O != $past(LINK_BIT_CLOCK_O)
         && !LINK_BIT_CLOCK_OE_N) else $error("bit clock not toggling"); // RQ6 RQ10
   a_hd_single_sample: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
      hd_l && !bclk_q && pos_q != last_pos |=> $stable(rx_cnt_q))
      else $error("input sampled twice per bit"); // RQ8
   a_strap_released: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
      !drive_l |=> FRAME_SYNC_OE_N && SERIAL_OUT_LINE_OE_N) else $error("strap pin driven"); // RQ9
   a_sdo_idle_outside: assert property (@(posedge LINK_CLK) disable iff (!lrst_n_q)
      pos_q < sync_len |=> !SERIAL_OUT_LINE_O) else $error("data during sync head"); // RQ7
endmodule
`default_nettype wire

// ==== acl_codec_model.sv ====
/*
 codec side model: makes the link clock, reads sync and data out, returns words.
 assumes the bench resolves the shared pins and feeds their levels in.
*/
`timescale 1ns/1ps
`default_nettype none
module acl_codec_model import acl_pkg::*; #(
   parameter int DATA_W = 20
) (
   input wire logic hd,
   input wire logic fs,
   input wire logic sdo,
   input wire logic [3*DATA_W-1:0] words,
   output logic bclk,
   output logic [2:0] sdi,
   output logic [DATA_W-1:0] got_word,
   output logic [STREAM_W-1:0] got_stream,
   output int frame_len
);
   int cnt = 0;
   int c;
   int l;
   int j;
   logic fs_q = 1'b0;
   logic [DATA_W-1:0] sh = '0;
   // runs free, as a codec bit clock does; in hd mode it is the reference
   initial begin
      bclk = 1'b0;
      forever #6 bclk = ~bclk;
   end
   initial begin
      sdi = 3'h0;
      got_word = '0;
      got_stream = '0;
      frame_len = 0;
   end
   always @(posedge bclk) begin
      l = hd ? 16'h8 : 16'h10;
      // stream bits ride on sync, so a rise inside the stream field is no frame start
      c = (fs && !fs_q && cnt >= l + 4) ? 0 : cnt + 1;
      fs_q <= fs;
      cnt <= c;
      if (c == 0) frame_len <= cnt + 1;
      if (c >= l && c < l + 4) got_stream[l + 3 - c] <= fs;
      if (c >= l + 4 && c < l + 4 + DATA_W) sh[l + 3 + DATA_W - c] <= sdo;
      // an all-zero frame means no new word, so the last real one is kept
      if (c == l + 4 + DATA_W && sh != '0) got_word <= sh;
      // the host samples four slots after our write; in hd it samples the odd slots
      j = (c < l) ? -1 : (hd ? (c - l - 1) / 2 : c - l);
      if (j >= 0 && j < DATA_W) begin
         for (int k = 0; k < 3; k++) sdi[k] <= words[k * DATA_W + DATA_W - 1 - j];
      end else begin
         sdi <= ~sdi;
      end
   end
endmodule
`default_nettype wire

// ==== tb_audio_codec_link_host.sv ====
/*
 self-checking bench for the link host with a codec model on the far side.
 assumes the design's reset and strap timing as handed over; legacy and hd runs.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_audio_codec_link_host;
   import acl_pkg::*;
   localparam int DW = 20;
   logic CLK = 1'b0;
   logic RESETN = 1'b0;
   logic HD_MODE = 1'b0;
   logic CODEC_RESET_HOLD = 1'b0;
   logic TX_LOAD = 1'b0;
   logic [STREAM_W-1:0] STREAM_NUM = '0;
   logic [DW-1:0] TX_DATA = '0;
   logic strap_fs = 1'b0;
   logic strap_sdo = 1'b0;
   logic [3*DW-1:0] words = '0;
   logic [31:0] seed = 32'hD0AA;
   int bad_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int bc = 0;
   int lc = 0;
   wire logic tx_ready, rx_valid, crst_n, s_sync, s_sdo, fs_o, fs_oe_n, sdo_o, sdo_oe_n;
   wire logic bck_o, bck_oe_n, link_clk;
   wire logic [2:0] sdi;
   wire logic [DW-1:0] rx0, rx1, rx2, got_word;
   wire logic [STREAM_W-1:0] got_stream;
   int frame_len;
   // released strap pins show the level the board straps them to
   wire logic fs_pin = fs_oe_n ? strap_fs : fs_o;
   wire logic sdo_pin = sdo_oe_n ? strap_sdo : sdo_o;
   acl_link #(.DATA_W(DW)) dut (.CLK(CLK), .RESETN(RESETN), .LINK_CLK(link_clk),
      .HD_MODE(HD_MODE), .CODEC_RESET_HOLD(CODEC_RESET_HOLD), .STREAM_NUM(STREAM_NUM),
      .TX_LOAD(TX_LOAD), .TX_DATA(TX_DATA), .TX_READY(tx_ready), .RX_DATA0(rx0),
      .RX_DATA1(rx1), .RX_DATA2(rx2), .RX_VALID(rx_valid), .CODEC_RESET_N(crst_n),
      .STRAP_SYNC(s_sync), .STRAP_SDO(s_sdo), .FRAME_SYNC_O(fs_o),
      .FRAME_SYNC_OE_N(fs_oe_n), .FRAME_SYNC_I(fs_pin), .SERIAL_OUT_LINE_O(sdo_o),
      .SERIAL_OUT_LINE_OE_N(sdo_oe_n), .SERIAL_OUT_LINE_I(sdo_pin),
      .LINK_BIT_CLOCK_O(bck_o), .LINK_BIT_CLOCK_OE_N(bck_oe_n), .SERIAL_IN_LINES(sdi));
   acl_codec_model #(.DATA_W(DW)) codec (.hd(HD_MODE), .fs(fs_pin), .sdo(sdo_pin),
      .words(words), .bclk(link_clk), .sdi(sdi), .got_word(got_word),
      .got_stream(got_stream), .frame_len(frame_len));
   initial begin
      forever #12.5 CLK = ~CLK;
   end
   always @(posedge bck_o) bc++;
   always @(posedge link_clk) lc++;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic report_and_stop();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         report_and_stop();
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   task automatic wait_ready();
      int n;
      n = 0;
      while (tx_ready !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      chk(64'(tx_ready), 64'h1);
   endtask
   task automatic run_mode(input logic hd, input logic hold);
      logic [31:0] r;
      logic [DW-1:0] w;
      int fc;
      int n;
      fc = hd ? 500 : 130;
      RESETN <= 1'b0;
      HD_MODE <= hd;
      CODEC_RESET_HOLD <= hold;
      r = rnd();
      strap_fs <= r[0];
      strap_sdo <= r[1];
      tick(20);
      chk(64'(crst_n), 64'h0);
      chk(64'({fs_oe_n, sdo_oe_n, bck_oe_n}), 64'h7);
      RESETN <= 1'b1;
      tick(STRAP_HOLD_CYC + CRST_DELAY_CYC - 5);
      chk(64'({s_sync, s_sdo}), 64'({strap_fs, strap_sdo}));
      chk(64'(crst_n), 64'h0);
      tick(10);
      chk(64'(crst_n), 64'(!hold));
      chk(64'(bck_oe_n), 64'(!hd));
      if (hold) return;
      for (int t = 0; t < 3; t++) begin
         wait_ready();
         r = rnd();
         w = r[DW-1:0] | 20'h00001;
         TX_DATA <= w;
         STREAM_NUM <= r[31:28];
         TX_LOAD <= 1'b1;
         tick(1);
         TX_LOAD <= 1'b0;
         tick(1);
         TX_DATA <= ~w;
         TX_LOAD <= 1'b1;
         tick(1);
         TX_LOAD <= 1'b0;
         wait_ready();
         tick(2 * fc);
         chk(64'(got_word), 64'(w));
         chk(64'(got_stream), 64'(r[31:28]));
      end
      chk(64'(frame_len), hd ? 64'h3E8 : 64'h100);
      r = rnd();
      words <= {rnd(), r[27:0]};
      tick(2 * fc);
      n = 0;
      while (rx_valid !== 1'b1 && n < 2000) begin
         tick(1);
         n++;
      end
      chk(64'(rx_valid), 64'h1);
      chk(64'({rx2, rx1, rx0}), 64'(words));
      bc = 0;
      lc = 0;
      tick(400);
      chk(64'(hd ? (bc * 2 >= lc - 2 && bc * 2 <= lc + 2) : bc == 0), 64'h1);
   endtask
   initial begin
      tick(1);
      run_mode(1'b0, 1'b1);
      run_mode(1'b0, 1'b0);
      run_mode(1'b1, 1'b0);
      report_and_stop();
   end
endmodule
`default_nettype wire
